//--- common/wic_pkg.sv
// Package of constants for the watchdog and idle control block.
// Assumes a 100 MHz clock standing in for the oscillator clock.
package wic_pkg;
    // ************************************************************
    // Special function register addresses
    // ************************************************************
    localparam logic [7:0] WIC_ADDR_WDOG_COUNT = 8'hff;
    localparam logic [7:0] WIC_ADDR_PWR_CTRL = 8'h87;
    // ************************************************************
    // Power control field positions
    // ************************************************************
    localparam int WIC_BIT_IDLE_SELECT = 0;
    localparam int WIC_BIT_GEN_FLAG_ZERO = 2;
    localparam int WIC_BIT_GEN_FLAG_ONE = 3;
    localparam int WIC_BIT_LOAD_ENABLE = 4;
    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [7:0] WIC_WDOG_COUNT_RESET = 8'h00;
    localparam logic [7:0] WIC_PWR_CTRL_RESET = 8'h00;
    localparam logic [3:0] WIC_MACHINE_DIV = 4'hc;
    localparam int WIC_PRESCALE_WIDTH = 11;
    localparam int WIC_COUNTER_WIDTH = 8;
    localparam logic [2:0] WIC_RESET_PULSE_CYCLES = 3'h4;
    localparam logic [7:0] WIC_OSD_BG_POLARITY_BIT = 8'h04;
endpackage

//--- verilog/wic_counter.sv
// Counter with enable, synchronous clear, load and carry out.
// Assumes one clock and a synchronous active high clear.
`timescale 1ns/1ns
module wic_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clock_in, // Clock
    input wire logic clear_in, // Synchronous clear
    input wire logic enable_in, // Count enable
    input wire logic load_in, // Load strobe
    input wire logic [WIDTH-1:0] load_value_in, // Load value
    output logic [WIDTH-1:0] count_out, // Count value
    output logic wrap_out // All ones while enabled
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    wire at_top = &count_q;
    assign wrap_out = enable_in & at_top;
    assign count_out = count_q;
    always_comb begin
        count_d = count_q;
        if (load_in) begin
            count_d = load_value_in;
        end else if (enable_in) begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    always_ff @(posedge clock_in) begin
        if (clear_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

//--- verilog/wic_sync.sv
// Two flip-flop synchroniser for a group of level inputs.
// Assumes inputs from pins outside the clock domain.
`timescale 1ns/1ns
module wic_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clock_in, // Clock
    input wire logic srst_in, // Synchronous reset
    input wire logic [WIDTH-1:0] async_in, // Raw levels
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    assign sync_out = sync_q;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule

//--- verilog/wic_top.sv
// Watchdog timer and idle mode control for an 8-bit controller.
// Assumes a CPU side special function register port on clock_in.
// Notes on behaviour
// R1 - Watchdog: 11-bit prescaler then 8-bit counter
// R2 - Counter steps once per 12 x 2048 periods
// R3 - Counts upward from loaded value
// R4 - Overflow gives brief internal reset pulse
// R5 - No disable; software reloads in time
// R6 - Watchdog keeps running during idle
// R7 - Load accepted only while load enable set
// R8 - Successful load clears load enable
// R9 - System reset clears counter and prescaler
// R10 - Counter is full register at FFH
// R11 - Power control bit 0 enters idle
// R12 - Idle gates CPU and peripheral clocks
// R13 - Idle preserves state, RAM, registers, pins; here the pin outputs are driven to the R20 levels instead
// R14 - Timer or external irq clears idle
// R15 - Idle blocks new non-wake interrupts
// R16 - Pending enabled interrupt wakes at once
// R17 - External reset in idle two cycles
// R18 - Reset clears registers, keeps RAM
// R19 - Overflow in idle resets, ends idle
// R20 - Idle pin levels: PWM low, others fixed
// R21 - Idle write may set general flags
// R22 - Load enable at power control bit 4
// R23 - Power control at 87H with flag bits
// R24 - Refused load leaves count and enable
`timescale 1ns/1ns
module wic_top
    import wic_pkg::*;
(
    input wire logic clock_in, // Oscillator clock
    input wire logic srst_in, // System reset
    input wire logic sfr_write_in, // Register write strobe
    input wire logic sfr_read_in, // Register read strobe
    input wire logic [7:0] sfr_addr_in, // Register address
    input wire logic [7:0] sfr_wdata_in, // Write data
    output logic [7:0] sfr_rdata_out, // Read data
    output logic sfr_hit_out, // Address is ours
    input wire logic ext_irq_zero_in, // External interrupt 0 pin
    input wire logic ext_irq_one_in, // External interrupt 1 pin
    input wire logic timer0_irq_in, // Timer 0 interrupt
    input wire logic timer1_irq_in, // Timer 1 interrupt
    input wire logic other_irq_pending_in, // Enabled non-wake irq pending
    input wire logic other_irq_new_in, // New non-wake irq request
    output logic other_irq_pass_out, // Non-wake irq let through
    input wire logic [7:0] osd_control_reg_in, // Display control value
    input wire logic [7:0] analog_pwm_outs_in, // PWM levels from units
    input wire logic tuning_pwm_in, // Tuning PWM level
    input wire logic i2c_out_in, // I2C output level
    input wire logic [3:0] rgb_fb_in, // Colour and blank levels
    output logic [7:0] analog_pwm_outs_out, // PWM pins
    output logic tuning_pwm_out, // Tuning PWM pin
    output logic i2c_out_out, // I2C output pin
    output logic [2:0] colour_out, // Colour pins
    output logic fast_blank_out, // Blanking pin
    output logic cpu_clk_en_out, // CPU clock enable
    output logic periph_clk_en_out, // PWM ADC I2C OSD clock enable
    output logic hold_state_out, // Freeze CPU state and pins
    output logic machine_tick_out, // One machine cycle pulse
    output logic internal_reset_out, // Watchdog reset pulse
    output logic idle_out // Idle mode active
);
    // ************************************************************
    // Machine cycle divider
    // ************************************************************
    logic [3:0] div_q;
    logic [3:0] div_d;
    wire div_end = (div_q == WIC_MACHINE_DIV - 4'h1);
    assign div_d = div_end ? 4'h0 : div_q + 4'h1;
    assign machine_tick_out = div_end;
    // ************************************************************
    // Register decode
    // ************************************************************
    logic wdog_load_enable_q;
    logic general_flag_one_q;
    logic general_flag_zero_q;
    logic idle_select_q;
    logic [2:0] rst_cnt_q;
    logic wdog_rst_q;
    wire int_rst = srst_in | wdog_rst_q; // R4 R18 R19
    wire hit_wdog = (sfr_addr_in == WIC_ADDR_WDOG_COUNT); // R10
    wire hit_pwr = (sfr_addr_in == WIC_ADDR_PWR_CTRL); // R23
    wire wr_wdog = sfr_write_in & hit_wdog;
    wire wr_pwr = sfr_write_in & hit_pwr;
    wire wdog_load = wr_wdog & wdog_load_enable_q; // R7 R24
    assign sfr_hit_out = hit_wdog | hit_pwr;
    // ************************************************************
    // Watchdog chain
    // ************************************************************
    logic [WIC_PRESCALE_WIDTH-1:0] pre_count;
    logic [WIC_COUNTER_WIDTH-1:0] wdog_count;
    logic pre_wrap;
    logic wdog_wrap;
    // R1 R2 R6 R9: prescaler on machine ticks, never gated by idle
    wic_counter #(.WIDTH(WIC_PRESCALE_WIDTH)) u_prescale (
        .clock_in(clock_in),
        .clear_in(int_rst),
        .enable_in(machine_tick_out),
        .load_in(1'b0),
        .load_value_in({WIC_PRESCALE_WIDTH{1'b0}}),
        .count_out(pre_count),
        .wrap_out(pre_wrap)
    );
    // R3 R5: up counter, no disable path
    wic_counter #(.WIDTH(WIC_COUNTER_WIDTH)) u_watchdog_counter (
        .clock_in(clock_in),
        .clear_in(int_rst),
        .enable_in(pre_wrap),
        .load_in(wdog_load),
        .load_value_in(sfr_wdata_in),
        .count_out(wdog_count),
        .wrap_out(wdog_wrap)
    );
    // ************************************************************
    // Wake input synchronisers
    // ************************************************************
    logic [1:0] ext_sync;
    wic_sync #(.WIDTH(2)) u_ext_sync (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .async_in({ext_irq_one_in, ext_irq_zero_in}),
        .sync_out(ext_sync)
    );
    wire wake = (|ext_sync) | timer0_irq_in | timer1_irq_in; // R14
    // ************************************************************
    // Reset pulse, divider and power control
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_d;
        end
    end
    // R4: fixed length pulse after overflow
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rst_cnt_q <= 3'h0;
            wdog_rst_q <= 1'b0;
        end else if (wdog_wrap && !wdog_load) begin
            rst_cnt_q <= WIC_RESET_PULSE_CYCLES - 3'h1;
            wdog_rst_q <= 1'b1;
        end else if (rst_cnt_q != 3'h0) begin
            rst_cnt_q <= rst_cnt_q - 3'h1;
        end else begin
            wdog_rst_q <= 1'b0;
        end
    end
    always_ff @(posedge clock_in) begin
        if (int_rst) begin
            wdog_load_enable_q <= WIC_PWR_CTRL_RESET[WIC_BIT_LOAD_ENABLE]; // R18
            general_flag_one_q <= WIC_PWR_CTRL_RESET[WIC_BIT_GEN_FLAG_ONE];
            general_flag_zero_q <= WIC_PWR_CTRL_RESET[WIC_BIT_GEN_FLAG_ZERO];
            idle_select_q <= WIC_PWR_CTRL_RESET[WIC_BIT_IDLE_SELECT];
        end else begin
            if (wr_pwr) begin
                wdog_load_enable_q <= sfr_wdata_in[WIC_BIT_LOAD_ENABLE]; // R22
                general_flag_one_q <= sfr_wdata_in[WIC_BIT_GEN_FLAG_ONE]; // R21
                general_flag_zero_q <= sfr_wdata_in[WIC_BIT_GEN_FLAG_ZERO]; // R21
            end else if (wdog_load) begin
                wdog_load_enable_q <= 1'b0; // R8
            end
            // Wake wins over a concurrent idle write
            if (wake || (idle_select_q && other_irq_pending_in)) begin
                idle_select_q <= 1'b0; // R14 R16
            end else if (wr_pwr) begin
                idle_select_q <= sfr_wdata_in[WIC_BIT_IDLE_SELECT]; // R11
            end
        end
    end
    // ************************************************************
    // Read mux and idle outputs
    // ************************************************************
    wire [7:0] pwr_read = {3'h0, wdog_load_enable_q, general_flag_one_q, general_flag_zero_q, 1'b0, idle_select_q};
    wire [7:0] read_mux = hit_wdog ? wdog_count : (hit_pwr ? pwr_read : 8'h00);
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_read_in) begin
            sfr_rdata_out <= read_mux; // R10
        end
    end
    wire blank_level = ~|(osd_control_reg_in & WIC_OSD_BG_POLARITY_BIT);
    assign idle_out = idle_select_q;
    assign cpu_clk_en_out = ~idle_select_q; // R12
    assign periph_clk_en_out = ~idle_select_q; // R12
    assign hold_state_out = idle_select_q; // R13
    assign other_irq_pass_out = other_irq_new_in & ~idle_select_q; // R15
    assign internal_reset_out = wdog_rst_q;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            analog_pwm_outs_out <= 8'h00;
            tuning_pwm_out <= 1'b0;
            i2c_out_out <= 1'b1;
            colour_out <= 3'h0;
            fast_blank_out <= 1'b0;
        end else if (idle_select_q) begin
            analog_pwm_outs_out <= 8'h00; // R20
            tuning_pwm_out <= 1'b0;
            i2c_out_out <= 1'b1;
            colour_out <= {3{blank_level}};
            fast_blank_out <= blank_level;
        end else begin
            analog_pwm_outs_out <= analog_pwm_outs_in;
            tuning_pwm_out <= tuning_pwm_in;
            i2c_out_out <= i2c_out_in;
            colour_out <= rgb_fb_in[2:0];
            fast_blank_out <= rgb_fb_in[3];
        end
    end
endmodule

//--- test/wic_top_sva.sv
// Checker for the watchdog and idle control top module.
// Assumes a bind onto wic_top with ports matched by name.
`timescale 1ns/1ns
module wic_top_sva
    import wic_pkg::*;
(
    input wire logic clock_in, // Clock
    input wire logic srst_in, // Reset
    input wire logic sfr_read_in, // Read strobe
    input wire logic [7:0] sfr_addr_in, // Address
    input wire logic [7:0] sfr_rdata_out, // Read data
    input wire logic sfr_hit_out, // Hit
    input wire logic timer0_irq_in, // Timer 0 irq
    input wire logic other_irq_pending_in, // Pending irq
    input wire logic other_irq_new_in, // New irq
    input wire logic other_irq_pass_out, // Passed irq
    input wire logic [7:0] osd_control_reg_in, // Display control
    input wire logic [7:0] analog_pwm_outs_out, // PWM pins
    input wire logic tuning_pwm_out, // Tuning pin
    input wire logic i2c_out_out, // I2C pin
    input wire logic [2:0] colour_out, // Colour pins
    input wire logic fast_blank_out, // Blank pin
    input wire logic cpu_clk_en_out, // CPU clock enable
    input wire logic periph_clk_en_out, // Peripheral enable
    input wire logic hold_state_out, // Hold
    input wire logic machine_tick_out, // Tick
    input wire logic internal_reset_out, // Watchdog reset
    input wire logic idle_out // Idle
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    tick_period_a: assert property (machine_tick_out |=> !machine_tick_out[*8] ##1 !machine_tick_out
        ##1 !machine_tick_out ##1 !machine_tick_out ##1 machine_tick_out) else $error("tick period wrong");
    pulse_len_a: assert property ($rose(internal_reset_out) |-> internal_reset_out[*4]
        ##1 !internal_reset_out) else $error("reset pulse length wrong");
    overflow_idle_a: assert property ($rose(internal_reset_out) |=> !idle_out)
        else $error("overflow left idle on");
    clk_gate_a: assert property (cpu_clk_en_out == !idle_out && periph_clk_en_out == !idle_out)
        else $error("clock enables wrong");
    hold_state_a: assert property (hold_state_out == idle_out) else $error("hold wrong");
    wake_timer_a: assert property (idle_out && timer0_irq_in |=> !idle_out) else $error("no wake");
    irq_block_a: assert property (other_irq_pass_out == (other_irq_new_in && !idle_out))
        else $error("irq pass wrong");
    pending_wake_a: assert property (idle_out && other_irq_pending_in |=> !idle_out)
        else $error("pending irq did not wake");
    idle_pins_a: assert property (idle_out && $past(idle_out) |-> analog_pwm_outs_out == 8'h00
        && !tuning_pwm_out && i2c_out_out && colour_out == {3{~$past(osd_control_reg_in[2])}}
        && fast_blank_out == ~$past(osd_control_reg_in[2])) else $error("idle pins wrong");
    addr_hit_a: assert property (sfr_hit_out == (sfr_addr_in == WIC_ADDR_WDOG_COUNT
        || sfr_addr_in == WIC_ADDR_PWR_CTRL)) else $error("hit decode wrong");
    unmapped_read_a: assert property (sfr_read_in && !sfr_hit_out |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule

//--- test/test_watchdog_and_idle_control.sv
// Testbench for the watchdog and idle control block.
// Assumes wic_top and its checker are compiled alongside.
`timescale 1ns/1ns
module test_watchdog_and_idle_control;
    import wic_pkg::*;
    logic clock_in = 1'b0, srst_in = 1'b1, sfr_write_in = 1'b0, sfr_read_in = 1'b0;
    logic ext_irq_zero_in = 1'b0, ext_irq_one_in = 1'b0, timer0_irq_in = 1'b0, timer1_irq_in = 1'b0;
    logic other_irq_pending_in = 1'b0, other_irq_new_in = 1'b0, tuning_pwm_in = 1'b1, i2c_out_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, osd_control_reg_in = 8'h04, analog_pwm_outs_in = 8'ha5;
    logic [3:0] rgb_fb_in = 4'h5;
    logic [7:0] sfr_rdata_out, analog_pwm_outs_out;
    logic [2:0] colour_out;
    logic sfr_hit_out, other_irq_pass_out, tuning_pwm_out, i2c_out_out, fast_blank_out, cpu_clk_en_out;
    logic periph_clk_en_out, hold_state_out, machine_tick_out, internal_reset_out, idle_out;
    int n_errors = 0, checks = 0, n;
    wic_top i_dut (.*);
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(negedge clock_in) {sfr_write_in, sfr_addr_in, sfr_wdata_in} = {1'b1, a, d};
        @(negedge clock_in) sfr_write_in = 1'b0;
    endtask
    task rd(input logic [7:0] a, e);
        @(negedge clock_in) {sfr_read_in, sfr_addr_in} = {1'b1, a};
        @(negedge clock_in) sfr_read_in = 1'b0;
        chk(sfr_rdata_out === e, "read data mismatch");
    endtask
    task wait_pulse(output int c);
        c = 0;
        while (internal_reset_out !== 1'b1 && c < 30000) begin
            @(negedge clock_in);
            c++;
        end
    endtask
    task conclude;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        conclude;
    end
    initial begin
        repeat (2) @(posedge clock_in);
        @(negedge clock_in) srst_in = 1'b0;
        rd(WIC_ADDR_WDOG_COUNT, 8'h00);
        rd(WIC_ADDR_PWR_CTRL, 8'h00);
        rd(8'h80, 8'h00);
        wr(WIC_ADDR_WDOG_COUNT, 8'hfe);
        rd(WIC_ADDR_WDOG_COUNT, 8'h00);
        wr(WIC_ADDR_PWR_CTRL, 8'hff);
        rd(WIC_ADDR_PWR_CTRL, 8'h1d);
        wr(WIC_ADDR_PWR_CTRL, 8'h10);
        rd(WIC_ADDR_PWR_CTRL, 8'h10);
        wr(WIC_ADDR_WDOG_COUNT, 8'hfe);
        rd(WIC_ADDR_WDOG_COUNT, 8'hfe);
        rd(WIC_ADDR_PWR_CTRL, 8'h00);
        chk(analog_pwm_outs_out === 8'ha5 && tuning_pwm_out === 1'b1, "pins not passed");
        for (int i = 0; i < 4; i++) begin
            wr(WIC_ADDR_PWR_CTRL, 8'h0d);
            @(negedge clock_in) other_irq_new_in = 1'b1;
            chk(idle_out === 1'b1 && other_irq_pass_out === 1'b0, "idle not entered");
            chk(analog_pwm_outs_out === 8'h00 && i2c_out_out === 1'b1 && colour_out === 3'h0, "idle pins");
            other_irq_new_in = 1'b0;
            {ext_irq_zero_in, ext_irq_one_in, timer0_irq_in, timer1_irq_in} = 4'h8 >> i;
            repeat (4) @(negedge clock_in);
            chk(idle_out === 1'b0, "no wake from source");
            {ext_irq_zero_in, ext_irq_one_in, timer0_irq_in, timer1_irq_in} = 4'h0;
            rd(WIC_ADDR_PWR_CTRL, 8'h0c);
            repeat (3) @(negedge clock_in);
        end
        other_irq_pending_in = 1'b1;
        wr(WIC_ADDR_PWR_CTRL, 8'h01);
        @(negedge clock_in) chk(idle_out === 1'b0, "pending irq did not wake");
        other_irq_pending_in = 1'b0;
        wr(WIC_ADDR_PWR_CTRL, 8'h0d);
        @(negedge clock_in) srst_in = 1'b1;
        repeat (24) @(negedge clock_in);
        srst_in = 1'b0;
        chk(idle_out === 1'b0, "reset kept idle");
        rd(WIC_ADDR_PWR_CTRL, 8'h00);
        wr(WIC_ADDR_PWR_CTRL, 8'h10);
        wr(WIC_ADDR_WDOG_COUNT, 8'hff);
        wr(WIC_ADDR_PWR_CTRL, 8'h01);
        wait_pulse(n);
        chk(n < 30000, "no overflow in idle");
        repeat (5) @(negedge clock_in);
        chk(idle_out === 1'b0, "idle kept after overflow");
        rd(WIC_ADDR_WDOG_COUNT, 8'h00);
        wr(WIC_ADDR_PWR_CTRL, 8'h10);
        wr(WIC_ADDR_WDOG_COUNT, 8'hff);
        wait_pulse(n);
        n = n + 12;
        chk(n > 24552 && n < 24600, "overflow interval wrong");
        conclude;
    end
endmodule
bind wic_top wic_top_sva i_sva (.*);
